// ### rtl/srw_top.sv
// supervisor: reset hold-off sequencer and kick watchdog
`timescale 1ns/100ps
`include "srw_regs.svh"
module srw_top #(
  parameter int TICK_CYCLES = `SRW_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic supply_ok_in,
  input wire logic manual_clear_in_n,
  input wire logic kick_input_in,
  output logic kick_input_out,
  output logic kick_input_oe,
  output logic reset_out_n,
  output logic reset_out
);
  localparam srw_pkg::srw_pre_t PRE_LAST = `SRW_PRE_W'(TICK_CYCLES - 1);
  localparam srw_pkg::srw_cnt_t HOLD_LAST =
    `SRW_CNT_W'(`SRW_HOLD_TICKS - 1);
  localparam srw_pkg::srw_cnt_t WD_LAST = `SRW_CNT_W'(`SRW_KICK_TICKS - 1);
  localparam srw_pkg::srw_cnt_t SVC_AT =
    `SRW_CNT_W'(`SRW_KICK_TICKS * `SRW_SVC_NUM / `SRW_SVC_DEN);
  localparam int HOLD_CYC = TICK_CYCLES * `SRW_HOLD_TICKS;
  localparam int WD_CYC = TICK_CYCLES * `SRW_KICK_TICKS;

  //////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [2:0] pin_sync;
  logic supply_s;
  logic mr_s;
  logic kick_s;

  // all three pins are asynchronous to ref_clk [R12]
  srw_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in({kick_input_in, manual_clear_in_n, supply_ok_in}),
    .pin_sync(pin_sync)
  );
  assign supply_s = pin_sync[0];
  assign mr_s = pin_sync[1];
  assign kick_s = pin_sync[2];

  // prescaler wrap, shared by the hold-off and watchdog chains
  function automatic logic srw_tick(input srw_pkg::srw_pre_t pre);
    return pre == PRE_LAST;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // kick edge detection

  logic kick_d_reg;
  logic kick_d_next;
  logic kick_edge;

  // a 50ns pulse spans at least one 40ns edge, so the sampler sees it
  always_comb begin
    kick_d_next = kick_s;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      kick_d_reg <= 1'b0;
    end else begin
      kick_d_reg <= kick_d_next;
    end
  end

  assign kick_edge = kick_s ^ kick_d_reg; // either direction [R6]

  //////////////////////////////////////////////////////////////////////////
  // reset sequencer

  srw_pkg::srw_state_t state_reg;
  srw_pkg::srw_state_t state_next;
  srw_pkg::srw_pre_t hold_pre_reg;
  srw_pkg::srw_pre_t hold_pre_next;
  srw_pkg::srw_cnt_t hold_cnt_reg;
  srw_pkg::srw_cnt_t hold_cnt_next;
  logic rst_n_reg;
  logic rst_n_next;
  logic cause;
  logic expire;
  srw_pkg::srw_pre_t wd_pre_reg;
  srw_pkg::srw_cnt_t wd_cnt_reg;

  assign cause = !supply_s || !mr_s; // either holds reset [R2]
  // expiry only if the last tick arrives with no edge in the same cycle
  assign expire = (state_reg == srw_pkg::SRW_RUN) && srw_tick(wd_pre_reg)
    && (wd_cnt_reg == WD_LAST) && !kick_edge; // [R5]

  // counters idle at zero outside hold, so each entry times a full period
  always_comb begin
    state_next = state_reg;
    hold_pre_next = '0;
    hold_cnt_next = '0;
    case (state_reg)
      srw_pkg::SRW_ASSERT: begin
        if (!cause) begin
          state_next = srw_pkg::SRW_HOLD; // hold-off starts once clear [R2]
        end
      end
      srw_pkg::SRW_HOLD: begin
        if (cause) begin
          state_next = srw_pkg::SRW_ASSERT; // dip restarts timer [R3]
        end else if (srw_tick(hold_pre_reg)) begin
          if (hold_cnt_reg == HOLD_LAST) begin
            state_next = srw_pkg::SRW_RUN; // full hold-off elapsed [R1]
          end else begin
            hold_cnt_next = hold_cnt_reg + 1'b1;
          end
        end else begin
          hold_pre_next = hold_pre_reg + 1'b1; // prescaled timing [R12]
          hold_cnt_next = hold_cnt_reg;
        end
      end
      srw_pkg::SRW_RUN: begin
        if (cause) begin
          state_next = srw_pkg::SRW_ASSERT;
        end else if (expire) begin
          state_next = srw_pkg::SRW_HOLD; // expiry is a cause [R13]
        end
      end
      default: begin
        state_next = srw_pkg::SRW_ASSERT;
      end
    endcase
    rst_n_next = (state_next == srw_pkg::SRW_RUN);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= srw_pkg::SRW_ASSERT;
      hold_pre_reg <= '0;
      hold_cnt_reg <= '0;
      rst_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_pre_reg <= hold_pre_next;
      hold_cnt_reg <= hold_cnt_next;
      rst_n_reg <= rst_n_next;
    end
  end

  assign reset_out_n = rst_n_reg;
  assign reset_out = !rst_n_reg; // strict complement [R4]

  //////////////////////////////////////////////////////////////////////////
  // watchdog timer and internal kick driver

  srw_pkg::srw_pre_t wd_pre_next;
  srw_pkg::srw_cnt_t wd_cnt_next;
  logic kick_out_reg;
  logic kick_out_next;

  // counts only in steady run; the release cycle itself still leaves zero
  always_comb begin
    wd_pre_next = '0;
    wd_cnt_next = '0;
    if (state_next == srw_pkg::SRW_RUN && state_reg == srw_pkg::SRW_RUN
        && !kick_edge) begin // cleared in reset and on edges [R6] [R7]
      if (srw_tick(wd_pre_reg)) begin
        wd_cnt_next = wd_cnt_reg + 1'b1;
      end else begin
        wd_pre_next = wd_pre_reg + 1'b1;
        wd_cnt_next = wd_cnt_reg;
      end
    end
    // high only in the last eighth; the rise itself services the timer
    kick_out_next = (wd_cnt_next >= SVC_AT); // [R8] [R9]
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_pre_reg <= '0;
      wd_cnt_reg <= '0;
      kick_out_reg <= 1'b0;
    end else begin
      wd_pre_reg <= wd_pre_next;
      wd_cnt_reg <= wd_cnt_next;
      kick_out_reg <= kick_out_next;
    end
  end

  // weak drive: an external driver overrides it at the pin
  assign kick_input_out = kick_out_reg;
  assign kick_input_oe = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // checking helpers and assertions

  int hold_len_reg;
  int hold_len_next;
  int gap_reg;
  int gap_next;

  // hold cycles, and cycles of run since release or the last edge
  always_comb begin
    hold_len_next = (state_reg == srw_pkg::SRW_HOLD) ? hold_len_reg + 1 : 0;
    gap_next = (state_reg == srw_pkg::SRW_RUN && !kick_edge) ?
      gap_reg + 1 : 0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_len_reg <= 0;
      gap_reg <= 0;
    end else begin
      hold_len_reg <= hold_len_next;
      gap_reg <= gap_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_hold_full_len: assert property ( // [R1]
    $rose(reset_out_n) |-> hold_len_reg == HOLD_CYC)
    else $error("hold-off length wrong at reset release");
  a_cause_holds_low: assert property ( // [R2]
    cause |=> !reset_out_n [*2])
    else $error("reset released while a cause is active");
  a_dip_restarts: assert property ( // [R3]
    !supply_s |=> ##1 (hold_len_reg == 0))
    else $error("supply dip did not restart hold-off");
  a_pair_inverse: assert property ( // [R4]
    reset_out == !reset_out_n)
    else $error("reset outputs not complementary");
  // a cause in the expiry cycle wins and goes straight to assert instead
  a_expiry_resets: assert property ( // [R5] [R13]
    expire && !cause |=> !reset_out_n ##0 (state_reg == srw_pkg::SRW_HOLD))
    else $error("watchdog expiry did not assert reset");
  a_edge_clears: assert property ( // [R6]
    kick_edge |=> (wd_cnt_reg == '0) && (wd_pre_reg == '0))
    else $error("kick edge did not clear watchdog");
  a_wd_stopped: assert property ( // [R7]
    !reset_out_n |-> (wd_cnt_reg == '0) && (wd_pre_reg == '0))
    else $error("watchdog counting during reset");
  a_gap_bound: assert property ( // [R5]
    gap_reg <= WD_CYC + 1)
    else $error("watchdog exceeded timeout without reset");
  a_kick_rise_at: assert property ( // [R8]
    $rose(kick_input_out) |-> (wd_cnt_reg == SVC_AT) && (wd_pre_reg == '0))
    else $error("internal kick rose at wrong point");

  c_release: cover property ($rose(reset_out_n));
  c_expire: cover property (expire);
  c_self_kick: cover property ($rose(kick_input_out) ##[1:8] kick_edge);
  c_manual: cover property (reset_out_n ##1 !mr_s);
endmodule // srw_top

// ### rtl/srw_regs.svh
// timing constants and counter layout of the supervisor reset watchdog
// Function
// R1: reset output stays low for the hold-off period after every cause ends.
// R2: reset held low while supply is low or manual clear is low.
// R3: every supply dip restarts the hold-off timer from the start.
// R4: active-high reset output is always the inverse of the low one.
// R5: no kick edge within the kick timeout period forces a reset.
// R6: any rising or falling kick edge clears the watchdog, pulses down to 50ns.
// R7: watchdog held cleared during reset, counts from zero on release.
// R8: undriven kick pin is driven low for 7/8, high for last 1/8; code holds it high only until its own rise clears the watchdog.
// R9: self-driven kick clears the watchdog every 1.4s, so it never expires.
// R10: processor should keep kick low and pulse it within first 7/8.
// R11: processor sets kick high in main loop, low on subroutine entry.
// R12: periods come from prescaled clock counters; pin inputs are synchronised.
// R13: watchdog expiry asserts reset at once and times hold-off from it.
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

`define SRW_CLK_HZ 25000000
`define SRW_TICK_US 1000
`define SRW_TICK_CYCLES (`SRW_CLK_HZ / 1000000 * `SRW_TICK_US)
`define SRW_HOLD_OFF_MS 200
`define SRW_HOLD_TICKS (`SRW_HOLD_OFF_MS * 1000 / `SRW_TICK_US)
`define SRW_KICK_TIMEOUT_MS 1600
`define SRW_KICK_TICKS (`SRW_KICK_TIMEOUT_MS * 1000 / `SRW_TICK_US)
`define SRW_SVC_NUM 7
`define SRW_SVC_DEN 8
`define SRW_PRE_W 16
`define SRW_CNT_W 11

`endif

// ### rtl/srw_pkg.sv
// types shared by the supervisor reset watchdog files
`include "srw_regs.svh"
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_ASSERT,
    SRW_HOLD,
    SRW_RUN
  } srw_state_t;
  typedef logic [`SRW_PRE_W-1:0] srw_pre_t;
  typedef logic [`SRW_CNT_W-1:0] srw_cnt_t;
endpackage

// ### rtl/srw_sync.sv
// two-stage synchroniser for the three pin inputs
`timescale 1ns/100ps
module srw_sync (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_sync
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  // first stage feeds only the second; reset to zero counts as a cause
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule // srw_sync

// ### verification/srw_cpu_model.sv
// processor side of the kick pin: strong drive, else the weak self-drive
`timescale 1ns/100ps
module srw_cpu_model (
  input wire logic ref_clk,
  input wire logic drive_en,
  input wire logic drive_lvl,
  input wire logic kick_input_out,
  input wire logic kick_input_oe,
  output logic kick_pin
);
  logic last_reg;
  ////////////////////////////////////////////////////////////////////////////
  // remember the pin so an undriven pin can wander instead of holding
  always @(posedge ref_clk) begin
    last_reg <= kick_pin;
  end
  // processor drive overrides the weak internal driver on the shared pin
  always_comb begin
    if (drive_en) begin
      kick_pin = drive_lvl;
    end else if (kick_input_oe) begin
      kick_pin = kick_input_out;
    end else begin
      kick_pin = ~last_reg; // nobody drives: no stable level to trust
    end
  end
endmodule // srw_cpu_model

// ### verification/tb_supervisor_reset_watchdog.sv
// self-checking bench for the supervisor reset watchdog
`timescale 1ns/100ps
module tb_supervisor_reset_watchdog;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_ok_in = 1'b1;
  logic manual_clear_in_n = 1'b1;
  logic drive_en = 1'b0;
  logic drive_lvl = 1'b0;
  logic kick_pin, kick_out, kick_oe, reset_out_n, reset_out;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'h78624d2b;
  int n;
  ////////////////////////////////////////////////////////////////////////////
  // expected periods in clock cycles at the shortened tick
  function automatic int hold_cyc();
    return TK * 200;
  endfunction
  function automatic int tmo_cyc();
    return TK * 1600;
  endfunction
  function automatic int self_cyc();
    return tmo_cyc() * 7 / 8;
  endfunction
  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  srw_top #(.TICK_CYCLES(TK)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .supply_ok_in(supply_ok_in), .manual_clear_in_n(manual_clear_in_n),
    .kick_input_in(kick_pin), .kick_input_out(kick_out),
    .kick_input_oe(kick_oe), .reset_out_n(reset_out_n),
    .reset_out(reset_out));
  srw_cpu_model i_cpu (.ref_clk(ref_clk), .drive_en(drive_en),
    .drive_lvl(drive_lvl), .kick_input_out(kick_out),
    .kick_input_oe(kick_oe), .kick_pin(kick_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // count edges until reset_out_n reaches lvl; the bound stops a hang
  task automatic span(input logic lvl, input int lo, input int hi,
                      input string msg);
    n = 0;
    while (reset_out_n !== lvl && n < hi + 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, msg);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  // rise-to-rise time of the self kick
  task automatic self_period(output int c);
    c = 0;
    while (kick_out !== 1'b0 && c < 9000) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    while (kick_out !== 1'b1 && c < 9000) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // the two reset outputs must never agree
  always @(negedge ref_clk) begin
    if (arst_n) chk(reset_out === ~reset_out_n, "inverse output");
  end
  // watchdog: about 100k cycles, well above the planned run
  initial begin
    #(40 * 100000);
    mismatches++;
    $display("unexpected at %0t: run timed out", $time);
    complete_run();
  end
  initial begin
    idle(20);
    chk(reset_out_n === 1'b0 && reset_out === 1'b1, "in reset");
    chk(kick_out === 1'b0 && kick_oe === 1'b1, "kick drive");
    arst_n = 1'b1;
    span(1'b1, hold_cyc() + 2, hold_cyc() + 6, "power-up hold");
    $display("test power_up done");
    // supply cause, then manual cause, each with a supply dip mid hold-off
    for (int c = 0; c < 2; c++) begin
      idle(1);
      if (c == 0) supply_ok_in = 1'b0;
      else manual_clear_in_n = 1'b0;
      idle(5);
      chk(reset_out_n === 1'b0, "cause not seen");
      idle(1 + ($random(seed) & 63));
      chk(reset_out_n === 1'b0, "released during cause");
      supply_ok_in = 1'b1;
      manual_clear_in_n = 1'b1;
      idle(hold_cyc() / 2);
      supply_ok_in = 1'b0;
      idle(2 + ($random(seed) & 7));
      supply_ok_in = 1'b1;
      span(1'b1, hold_cyc() + 2, hold_cyc() + 5, "hold restart");
      $display("test cause %0d done", c);
    end
    // kicks during reset are ignored; timer starts at release
    idle(1);
    drive_en = 1'b1;
    manual_clear_in_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      idle(16);
      drive_lvl = 1'($random(seed)); // random levels reach the kick pin
    end
    manual_clear_in_n = 1'b1;
    span(1'b1, hold_cyc() + 2, hold_cyc() + 5, "manual hold");
    // processor hung with kick parked at one level
    span(1'b0, tmo_cyc() - 1, tmo_cyc() + 3, "expiry time");
    span(1'b1, hold_cyc() - 1, hold_cyc() + 2, "expiry hold");
    $display("test expiry done");
    // alternating rising and falling kicks just short of the timeout
    for (int k = 0; k < 6; k++) begin
      idle(tmo_cyc() - 200 - ($random(seed) & 1023));
      drive_lvl = ~drive_lvl;
      chk(reset_out_n === 1'b1, "kick missed");
    end
    // two-cycle pulse mid period, near the shortest width the pin must catch
    idle(tmo_cyc() / 2);
    drive_lvl = ~drive_lvl;
    idle(2);
    drive_lvl = ~drive_lvl;
    // without the pulse the timer would run out before this check
    idle(tmo_cyc() / 2 + 200);
    chk(reset_out_n === 1'b1, "short pulse missed");
    idle(2);
    chk(reset_out_n === 1'b1, "kick missed");
    $display("test kicks done");
    // pin released: self-drive must keep the watchdog serviced
    drive_en = 1'b0;
    self_period(n);
    for (int p = 0; p < 3; p++) begin
      self_period(n);
      chk(n >= self_cyc() && n <= self_cyc() + 12, "self kick");
      chk(reset_out_n === 1'b1, "floating expiry");
      chk(kick_oe === 1'b1, "weak drive off");
    end
    $display("test floating done");
    complete_run();
  end
endmodule // tb_supervisor_reset_watchdog
